// file: led_dim_map.svh
`ifndef LED_DIM_MAP_SVH
`define LED_DIM_MAP_SVH
`define CLK_MHZ            50
`define SETUP_NS           10000
`define LO_MIN_NS          200
`define LO_MAX_NS          100000
`define HI_MIN_NS          200
`define PWRDWN_NS          1500000
`define SETTLE_NS          40000
`define RATIO_DELAY_NS     400000
`define SETUP_CYC          ((`SETUP_NS * `CLK_MHZ + 999) / 1000)
`define LO_MIN_CYC         ((`LO_MIN_NS * `CLK_MHZ + 999) / 1000)
`define LO_MAX_CYC         ((`LO_MAX_NS * `CLK_MHZ) / 1000)
`define HI_MIN_CYC         ((`HI_MIN_NS * `CLK_MHZ + 999) / 1000)
`define PWRDWN_CYC         ((`PWRDWN_NS * `CLK_MHZ + 999) / 1000)
`define SETTLE_CYC         ((`SETTLE_NS * `CLK_MHZ) / 1000)
`define RATIO_DELAY_CYC    ((`RATIO_DELAY_NS * `CLK_MHZ) / 1000)
`define CNT_W              17
`define GAIN_FULL          3'h0
`define GAIN_LAST          3'h5
`define N_CH               3
`endif

// file: led_dim_pkg.sv
package led_dim_pkg;
  typedef enum logic [1:0] {RATIO_1X, RATIO_1P33X, RATIO_1P5X, RATIO_2X} pump_ratio_t;
  typedef enum {ST_SHUTDOWN, ST_ACTIVE} dev_state_t;
endpackage : led_dim_pkg

// file: led_dim_if.sv
`timescale 1ns/1ps
interface led_dim_if;
  logic enable_dim_input;
  modport host (output enable_dim_input);
  modport device (input enable_dim_input);
endinterface : led_dim_if

// file: dwell_counter.sv
`timescale 1ns/1ps
`include "led_dim_map.svh"
module dwell_counter
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // control
  input  wire logic              clear,
  // count
  output logic [`CNT_W-1:0]      count
);
  // saturating cycle counter, restarts on clear
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      count <= '0;
    else if (clear)
      count <= '0;
    else if (count != {`CNT_W{1'b1}})
      count <= count + `CNT_W'(1);
  end
endmodule : dwell_counter

// file: led_dim_device.sv
`timescale 1ns/1ps
`include "led_dim_map.svh"
module led_dim_device
#(
  parameter int PWRDWN_CYC      = `PWRDWN_CYC,
  parameter int RATIO_DELAY_CYC = `RATIO_DELAY_CYC
)
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  // link
  led_dim_if.device                  link,
  // analog indications
  input  wire logic                  undervoltage,
  input  wire logic                  overvoltage,
  input  wire logic                  over_temp,
  input  wire logic [`N_CH-1:0]      led_open,
  input  wire logic [`N_CH-1:0]      led_low_headroom,
  input  wire logic                  unity_ok,
  // outputs
  output logic                       enabled,
  output logic [2:0]                 gain_step,
  output logic                       settling,
  output logic [`N_CH-1:0]           led_current_sink_oe,
  output logic                       current_set_resistor_pin_oe,
  output led_dim_pkg::pump_ratio_t   pump_ratio
);
  logic                   sync1_reg;
  logic                   sync2_reg;
  logic                   line_prev_reg;
  logic [`CNT_W-1:0]      low_cnt;
  logic [`CNT_W-1:0]      high_cnt;
  logic [`CNT_W-1:0]      settle_cnt;
  logic [`CNT_W-1:0]      ratio_cnt;
  logic                   fault;
  logic                   rise;
  logic                   fall;
  logic                   lo_ok;
  logic                   need_up;
  logic                   hi_ok_reg;
  logic                   step;
  logic                   resume_reg;
  led_dim_pkg::dev_state_t state_reg;

  // input synchroniser
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg     <= 1'b0;
      sync2_reg     <= 1'b0;
      line_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg     <= link.enable_dim_input;
      sync2_reg     <= sync1_reg;
      line_prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~line_prev_reg;
  assign fall = ~sync2_reg & line_prev_reg;

  dwell_counter u_low
  (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .clear   (sync2_reg | fall),
    .count   (low_cnt)
  );

  dwell_counter u_high
  (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .clear   (rise),
    .count   (high_cnt)
  );

  // low length must sit in the programming window
  assign lo_ok = (low_cnt >= `CNT_W'(`LO_MIN_CYC)) && (low_cnt <= `CNT_W'(`LO_MAX_CYC));
  assign fault = undervoltage | over_temp | overvoltage;
  assign step  = rise && lo_ok && hi_ok_reg;

  // a high phase shorter than the minimum marks the next pulse as noise
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      hi_ok_reg <= 1'b0;
    else if (fall)
      hi_ok_reg <= (high_cnt >= `CNT_W'(`HI_MIN_CYC));
  end

  // enable state
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      state_reg <= led_dim_pkg::ST_SHUTDOWN;
    else if (fault)
      state_reg <= led_dim_pkg::ST_SHUTDOWN;
    else
    begin
      unique case (state_reg)
        led_dim_pkg::ST_SHUTDOWN:
          if (rise || (resume_reg && sync2_reg))
            state_reg <= led_dim_pkg::ST_ACTIVE;
        led_dim_pkg::ST_ACTIVE:
          if (!sync2_reg && (low_cnt >= `CNT_W'(PWRDWN_CYC)))
            state_reg <= led_dim_pkg::ST_SHUTDOWN;
          else if (rise && (low_cnt > `CNT_W'(`LO_MAX_CYC)))
            state_reg <= led_dim_pkg::ST_SHUTDOWN;
      endcase
    end
  end

  // thermal and overvoltage trips come back by themselves while the line stays high
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      resume_reg <= 1'b0;
    else if ((over_temp || overvoltage) && state_reg == led_dim_pkg::ST_ACTIVE)
      resume_reg <= 1'b1;
    else if (!sync2_reg || undervoltage || state_reg == led_dim_pkg::ST_ACTIVE)
      resume_reg <= 1'b0;
  end

  // gain step: 0 is full scale 132, 1..5 halve down to 4.125
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      gain_step <= `GAIN_FULL;
    else if (state_reg == led_dim_pkg::ST_SHUTDOWN)
      gain_step <= `GAIN_FULL;
    else if (step)
    begin
      if (gain_step == `GAIN_LAST)
        gain_step <= `GAIN_FULL;
      else
        gain_step <= gain_step + 3'h1;
    end
  end

  // settling flag after each gain step while active
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      settle_cnt <= '0;
    else if (state_reg == led_dim_pkg::ST_ACTIVE && step)
      settle_cnt <= `CNT_W'(`SETTLE_CYC);
    else if (settle_cnt != '0)
      settle_cnt <= settle_cnt - `CNT_W'(1);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enabled                     <= 1'b0;
      settling                    <= 1'b0;
      led_current_sink_oe         <= '0;
      current_set_resistor_pin_oe <= 1'b0;
    end
    else
    begin
      enabled                     <= (state_reg == led_dim_pkg::ST_ACTIVE);
      settling                    <= (settle_cnt != '0);
      // open channels are not driven either
      led_current_sink_oe         <= (state_reg == led_dim_pkg::ST_ACTIVE) ? ~led_open : '0;
      current_set_resistor_pin_oe <= (state_reg == led_dim_pkg::ST_ACTIVE);
    end
  end

  // pump ratio selection
  assign need_up = |(led_low_headroom & ~led_open);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pump_ratio <= led_dim_pkg::RATIO_1X;
      ratio_cnt  <= '0;
    end
    else if (fault || state_reg == led_dim_pkg::ST_SHUTDOWN)
    begin
      pump_ratio <= led_dim_pkg::RATIO_1X;
      ratio_cnt  <= '0;
    end
    else if (&led_open)
    begin
      pump_ratio <= led_dim_pkg::RATIO_1X;
      ratio_cnt  <= '0;
    end
    else if (unity_ok)
    begin
      pump_ratio <= led_dim_pkg::RATIO_1X;
      ratio_cnt  <= '0;
    end
    else if (need_up && pump_ratio != led_dim_pkg::RATIO_2X)
    begin
      if (ratio_cnt >= `CNT_W'(RATIO_DELAY_CYC - 1))
      begin
        pump_ratio <= led_dim_pkg::pump_ratio_t'(pump_ratio + 2'h1);
        ratio_cnt  <= '0;
      end
      else
        ratio_cnt <= ratio_cnt + `CNT_W'(1);
    end
    else
      ratio_cnt <= '0;
  end
endmodule : led_dim_device

// file: led_dim_host.sv
`timescale 1ns/1ps
`include "led_dim_map.svh"
module led_dim_host
#(
  parameter int PWRDWN_CYC = `PWRDWN_CYC
)
(
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  // user requests, one-cycle pulses
  input  wire logic   req_enable,
  input  wire logic   req_step,
  input  wire logic   req_shutdown,
  // status
  output logic        busy,
  // link
  led_dim_if.host     link
);
  typedef enum {H_OFF, H_SETUP, H_IDLE, H_LOW, H_HIGH, H_DOWN} host_state_t;
  host_state_t        state_reg;
  logic [`CNT_W-1:0]  cnt_reg;
  logic               line_reg;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= H_OFF;
      cnt_reg   <= '0;
      line_reg  <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_reg + `CNT_W'(1);
      unique case (state_reg)
        H_OFF:
          if (req_enable)
          begin
            state_reg <= H_SETUP;
            line_reg  <= 1'b1;
            cnt_reg   <= '0;
          end
        H_SETUP:
          if (cnt_reg >= `CNT_W'(`SETUP_CYC))
            state_reg <= H_IDLE;
        H_IDLE:
          if (req_shutdown)
          begin
            state_reg <= H_DOWN;
            line_reg  <= 1'b0;
            cnt_reg   <= '0;
          end
          else if (req_step)
          begin
            state_reg <= H_LOW;
            line_reg  <= 1'b0;
            cnt_reg   <= '0;
          end
        H_LOW:
          if (cnt_reg >= `CNT_W'(`LO_MIN_CYC + 4))
          begin
            state_reg <= H_HIGH;
            line_reg  <= 1'b1;
            cnt_reg   <= '0;
          end
        H_HIGH:
          if (cnt_reg >= `CNT_W'(`HI_MIN_CYC + 4))
            state_reg <= H_IDLE;
        H_DOWN:
          if (cnt_reg >= `CNT_W'(PWRDWN_CYC + 8))
            state_reg <= H_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy                  <= 1'b0;
    end
    else
    begin
      busy <= (state_reg != H_IDLE) && (state_reg != H_OFF);
    end
  end

  assign link.enable_dim_input = line_reg;
endmodule : led_dim_host

// file: led_dim_props.sv
`timescale 1ns/1ps
module led_dim_props
(
  // clock and reset
  input wire logic                     sys_clk,
  input wire logic                     rstn,
  // link and device signals
  input wire logic                     enable_dim_input,
  input wire logic                     undervoltage,
  input wire logic                     overvoltage,
  input wire logic [2:0]               led_open,
  input wire logic                     unity_ok,
  input wire logic                     enabled,
  input wire logic [2:0]               gain_step,
  input wire logic [2:0]               led_current_sink_oe,
  input wire logic                     current_set_resistor_pin_oe,
  input wire led_dim_pkg::pump_ratio_t pump_ratio
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  sequence off_run;
    !enabled [*3];
  endsequence
  sequence gain_moved;
    enabled [*4] ##0 $changed(gain_step);
  endsequence
  a_sink_hiz_off: assert property (off_run |-> led_current_sink_oe == 3'h0)
    else $error("sinks driven while off");
  a_current_set_resistor_pin_hiz_off: assert property (off_run |-> !current_set_resistor_pin_oe)
    else $error("set pin driven while off");
  a_off_unity_ratio: assert property (off_run |-> pump_ratio == led_dim_pkg::RATIO_1X)
    else $error("ratio not 1x while off");
  a_uv_shuts_down: assert property (undervoltage |-> ##[0:2] !enabled)
    else $error("undervoltage did not shut down");
  a_enable_full_gain: assert property ($rose(enabled) |-> ##[0:2] gain_step == 3'h0)
    else $error("enable not at full gain");
  a_rise_enables: assert property ($rose(enable_dim_input) && !enabled && !undervoltage
    && !overvoltage |-> ##[3:5] enabled)
    else $error("rise from off did not enable");
  a_gain_step_wrap: assert property (gain_moved |-> gain_step ==
    ($past(gain_step) == 3'h5 ? 3'h0 : $past(gain_step) + 3'h1))
    else $error("gain moved out of sequence");
  a_ratio_up_one: assert property (pump_ratio > $past(pump_ratio)
    |-> pump_ratio == $past(pump_ratio) + 2'h1)
    else $error("ratio skipped a step");
  a_ratio_down_unity: assert property (pump_ratio < $past(pump_ratio)
    |-> pump_ratio == led_dim_pkg::RATIO_1X)
    else $error("ratio fell to other than 1x");
  a_unity_ok_back: assert property (unity_ok |-> ##[1:2] pump_ratio == led_dim_pkg::RATIO_1X)
    else $error("unity ok did not give 1x");
  a_all_open_unity: assert property (led_open == 3'h7
    |-> ##[1:2] pump_ratio == led_dim_pkg::RATIO_1X)
    else $error("all open did not give 1x");
  a_ov_reruns: assert property (overvoltage |-> ##[1:2] pump_ratio == led_dim_pkg::RATIO_1X)
    else $error("overvoltage did not restart ratio");
endmodule : led_dim_props

// file: pulse_dimming_led_mode_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module pulse_dimming_led_mode_ctrl_test;
  localparam int PD = 6000;
  localparam int RD = 50;
  logic                     sys_clk = 1'b0;
  logic                     rstn = 1'b0;
  logic                     req_enable = 1'b0, req_step = 1'b0, req_shutdown = 1'b0;
  logic                     undervoltage = 1'b0, overvoltage = 1'b0, over_temp = 1'b0;
  logic [2:0]               led_open = 3'h0, led_low_headroom = 3'h0;
  logic                     unity_ok = 1'b0;
  logic                     busy, enabled, settling, current_set_resistor_pin_oe;
  logic [2:0]               gain_step, led_current_sink_oe;
  led_dim_pkg::pump_ratio_t pump_ratio;
  int                       bad_count = 0, n_compared = 0, cyc = 0;
  led_dim_if link_if();
  led_dim_host #(.PWRDWN_CYC(PD)) i_led_dim_host (.sys_clk(sys_clk), .rstn(rstn),
    .req_enable(req_enable), .req_step(req_step), .req_shutdown(req_shutdown),
    .busy(busy), .link(link_if));
  led_dim_device #(.PWRDWN_CYC(PD), .RATIO_DELAY_CYC(RD)) i_led_dim_device (
    .sys_clk(sys_clk), .rstn(rstn), .link(link_if), .undervoltage(undervoltage),
    .overvoltage(overvoltage), .over_temp(over_temp), .led_open(led_open),
    .led_low_headroom(led_low_headroom), .unity_ok(unity_ok), .enabled(enabled),
    .gain_step(gain_step), .settling(settling), .led_current_sink_oe(led_current_sink_oe),
    .current_set_resistor_pin_oe(current_set_resistor_pin_oe), .pump_ratio(pump_ratio));
  led_dim_props i_led_dim_props (.sys_clk(sys_clk), .rstn(rstn),
    .enable_dim_input(link_if.enable_dim_input), .undervoltage(undervoltage),
    .overvoltage(overvoltage), .led_open(led_open), .unity_ok(unity_ok),
    .enabled(enabled), .gain_step(gain_step), .led_current_sink_oe(led_current_sink_oe),
    .current_set_resistor_pin_oe(current_set_resistor_pin_oe), .pump_ratio(pump_ratio));
  always #10 sys_clk = ~sys_clk;
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // 0 enable, 1 step, 2 shutdown; returns at a falling edge once the line settled
  task automatic req(input int k);
    int w;
    w = 0;
    @(posedge sys_clk);
    req_enable <= (k == 0);
    req_step <= (k == 1);
    req_shutdown <= (k == 2);
    @(posedge sys_clk);
    {req_enable, req_step, req_shutdown} <= 3'h0;
    tick(1);
    @(negedge sys_clk);
    while (busy !== 1'b0 && w < 20000)
    begin
      @(negedge sys_clk);
      w++;
    end
    `CHK(busy, 1'b0)
    tick(8);
    @(negedge sys_clk);
  endtask : req
  task automatic wait_ratio(input int n, input led_dim_pkg::pump_ratio_t r);
    tick(n);
    @(negedge sys_clk);
    `CHK(pump_ratio, r)
  endtask : wait_ratio
  task automatic recover();
    req(2);
    req(0);
    `CHK(enabled, 1'b1)
  endtask : recover
  initial
  begin
    tick(12);
    rstn <= 1'b1;
    tick(2);
    @(negedge sys_clk);
    `CHK({enabled, led_current_sink_oe}, 4'h0)
    `CHK(current_set_resistor_pin_oe, 1'b0)
    `CHK(pump_ratio, led_dim_pkg::RATIO_1X)
    req(0);
    `CHK({enabled, gain_step, led_current_sink_oe}, 7'h47)
    for (int i = 1; i <= 6; i++)
    begin
      req(1);
      `CHK(gain_step, 3'(i % 6))
      `CHK(settling, 1'b1)
    end
    req(2);
    `CHK({enabled, led_current_sink_oe, current_set_resistor_pin_oe}, 5'h00)
    `CHK(settling, 1'b0)
    req(0);
    `CHK({enabled, gain_step, current_set_resistor_pin_oe}, 5'h11)
    @(posedge sys_clk);
    led_open <= 3'h2;
    led_low_headroom <= 3'h2;
    wait_ratio(3 * RD, led_dim_pkg::RATIO_1X);
    @(posedge sys_clk);
    led_open <= 3'h0;
    wait_ratio(RD + 10, led_dim_pkg::RATIO_1P33X);
    wait_ratio(2 * RD + 20, led_dim_pkg::RATIO_2X);
    @(posedge sys_clk);
    unity_ok <= 1'b1;
    wait_ratio(3, led_dim_pkg::RATIO_1X);
    @(posedge sys_clk);
    unity_ok <= 1'b0;
    led_low_headroom <= 3'h7;
    wait_ratio(RD + 10, led_dim_pkg::RATIO_1P33X);
    @(posedge sys_clk);
    led_open <= 3'h7;
    wait_ratio(3, led_dim_pkg::RATIO_1X);
    @(posedge sys_clk);
    led_open <= 3'h0;
    wait_ratio(RD + 10, led_dim_pkg::RATIO_1P33X);
    @(posedge sys_clk);
    overvoltage <= 1'b1;
    wait_ratio(3, led_dim_pkg::RATIO_1X);
    @(posedge sys_clk);
    overvoltage <= 1'b0;
    led_low_headroom <= 3'h0;
    tick(3);
    @(negedge sys_clk);
    `CHK(enabled, 1'b1)
    recover();
    @(posedge sys_clk);
    undervoltage <= 1'b1;
    tick(3);
    @(negedge sys_clk);
    `CHK({enabled, led_current_sink_oe}, 4'h0)
    @(posedge sys_clk);
    undervoltage <= 1'b0;
    recover();
    @(posedge sys_clk);
    over_temp <= 1'b1;
    tick(3);
    @(negedge sys_clk);
    `CHK(enabled, 1'b0)
    @(posedge sys_clk);
    over_temp <= 1'b0;
    tick(3);
    @(negedge sys_clk);
    `CHK(enabled, 1'b1)
    recover();
    print_verdict();
  end
endmodule : pulse_dimming_led_mode_ctrl_test
